// ### rtl/ite_entry_seq.sv
// exception entry sequencer: save state, update masks, load handler
`timescale 1ns/1ps
// Overview of operation
// - push pc, flags, extended register first
// - then update mask, clear trace bit
// - vector from source, load handler into pc
// - trap taken whenever exec_state is high, masks ignored
// - trap vector number eight to eleven, from trap number zero to three
module ite_entry_seq
  import ite_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // decode side
  input  wire logic                 exec_state,
  input  wire logic                 trap_req,
  input  wire logic [1:0]           trap_num,
  input  wire logic [ITE_PC_W-1:0]  cur_pc,
  input  wire logic [7:0]           cur_ccr,
  input  wire logic [7:0]           cur_xcr,
  // interrupt controller
  input  wire logic                 nmi_req,
  input  wire logic                 irq_req,
  input  wire logic [2:0]           irq_level,
  input  wire logic [ITE_VEC_W-1:0] irq_vector,
  input  wire logic                 mode_prio,
  // stack write port
  output logic                      stk_wr,
  output logic [ITE_STK_W-1:0]      stk_data,
  input  wire logic                 stk_ack,
  // vector fetch port
  output logic                      vec_rd,
  output logic [ITE_PC_W-1:0]       vec_addr,
  input  wire logic                 vec_ack,
  input  wire logic [ITE_PC_W-1:0]  vec_data,
  // results to core
  output logic                      busy,
  output logic                      ack_src,
  output logic                      pc_load,
  output logic [ITE_PC_W-1:0]       new_pc,
  output logic [7:0]                new_ccr,
  output logic [7:0]                new_xcr
);
  // -----------------------------------------------------------------
  // source selection
  // -----------------------------------------------------------------
  logic                 take;
  logic [ITE_VEC_W-1:0] sel_vec;
  logic [2:0]           sel_lvl;

  ite_arbiter u_arb (
    .trap_req   (trap_req & exec_state),
    .trap_num   (trap_num),
    .nmi_req    (nmi_req),
    .irq_req    (irq_req),
    .irq_level  (irq_level),
    .irq_vector (irq_vector),
    .mode_prio  (mode_prio),
    .ccr_imask  (cur_ccr[ITE_CCR_IMASK]),
    .xcr_mask   (cur_xcr[ITE_XCR_MSK_HI:ITE_XCR_MSK_LO]),
    .take       (take),
    .vector     (sel_vec),
    .new_level  (sel_lvl)
  );

  function automatic logic [ITE_PC_W-1:0] vec_to_addr(input logic [ITE_VEC_W-1:0] v);
    vec_to_addr = {{(ITE_PC_W-ITE_VEC_W-ITE_VEC_SHIFT){1'b0}}, v, {ITE_VEC_SHIFT{1'b0}}};
  endfunction : vec_to_addr

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  ite_state_t           st_q, st_d;
  logic [ITE_VEC_W-1:0] vec_q, vec_d;
  logic [2:0]           lvl_q, lvl_d;
  logic [ITE_PC_W-1:0]  pc_q, pc_d;
  logic [7:0]           ccr_q, ccr_d, xcr_q, xcr_d;
  logic                 stk_wr_q, stk_wr_d, vec_rd_q, vec_rd_d;
  logic [ITE_STK_W-1:0] stk_data_q, stk_data_d;
  logic [ITE_PC_W-1:0]  vec_addr_q, vec_addr_d, new_pc_q, new_pc_d;
  logic                 busy_q, busy_d, ack_q, ack_d, load_q, load_d;
  logic [7:0]           nccr_q, nccr_d, nxcr_q, nxcr_d;

  always_comb begin
    st_d       = st_q;
    vec_d      = vec_q;
    lvl_d      = lvl_q;
    pc_d       = pc_q;
    ccr_d      = ccr_q;
    xcr_d      = xcr_q;
    stk_wr_d   = stk_wr_q;
    stk_data_d = stk_data_q;
    vec_rd_d   = vec_rd_q;
    vec_addr_d = vec_addr_q;
    new_pc_d   = new_pc_q;
    busy_d     = busy_q;
    ack_d      = 1'b0;
    load_d     = 1'b0;
    nccr_d     = nccr_q;
    nxcr_d     = nxcr_q;
    case (st_q)
      ITE_IDLE: begin
        if (take) begin
          vec_d      = sel_vec;
          lvl_d      = sel_lvl;
          pc_d       = cur_pc;
          ccr_d      = cur_ccr;
          xcr_d      = cur_xcr;
          busy_d     = 1'b1;
          ack_d      = 1'b1;
          stk_wr_d   = 1'b1;
          stk_data_d = {ITE_STK_W'(cur_ccr) << ITE_PC_W} | ITE_STK_W'(cur_pc);
          st_d       = ITE_PUSH_PC;
        end
      end
      ITE_PUSH_PC: begin
        if (stk_ack) begin
          stk_data_d = ITE_STK_W'(xcr_q);
          st_d       = ITE_PUSH_FL;
        end
      end
      ITE_PUSH_FL: begin
        if (stk_ack) begin
          stk_wr_d = 1'b0;
          st_d     = ITE_MASK;
        end
      end
      ITE_MASK: begin
        nccr_d = ccr_q;
        nccr_d[ITE_CCR_IMASK] = 1'b1;
        nxcr_d = xcr_q;
        nxcr_d[ITE_XCR_MSK_HI:ITE_XCR_MSK_LO] = lvl_q;
        nxcr_d[ITE_XCR_TRACE] = 1'b0;
        vec_addr_d = vec_to_addr(vec_q);
        vec_rd_d   = 1'b1;
        st_d       = ITE_VWAIT;
      end
      ITE_VWAIT: begin
        if (vec_ack) begin
          vec_rd_d = 1'b0;
          new_pc_d = vec_data;
          load_d   = 1'b1;
          st_d     = ITE_DONE;
        end
      end
      ITE_DONE: begin
        busy_d = 1'b0;
        st_d   = ITE_IDLE;
      end
      default: st_d = ITE_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q       <= ITE_IDLE;
      vec_q      <= '0;
      lvl_q      <= '0;
      pc_q       <= '0;
      ccr_q      <= '0;
      xcr_q      <= '0;
      stk_wr_q   <= 1'b0;
      stk_data_q <= '0;
      vec_rd_q   <= 1'b0;
      vec_addr_q <= '0;
      new_pc_q   <= '0;
      busy_q     <= 1'b0;
      ack_q      <= 1'b0;
      load_q     <= 1'b0;
      nccr_q     <= ITE_CCR_RESET;
      nxcr_q     <= ITE_XCR_RESET;
    end else begin
      st_q       <= st_d;
      vec_q      <= vec_d;
      lvl_q      <= lvl_d;
      pc_q       <= pc_d;
      ccr_q      <= ccr_d;
      xcr_q      <= xcr_d;
      stk_wr_q   <= stk_wr_d;
      stk_data_q <= stk_data_d;
      vec_rd_q   <= vec_rd_d;
      vec_addr_q <= vec_addr_d;
      new_pc_q   <= new_pc_d;
      busy_q     <= busy_d;
      ack_q      <= ack_d;
      load_q     <= load_d;
      nccr_q     <= nccr_d;
      nxcr_q     <= nxcr_d;
    end
  end

  assign stk_wr   = stk_wr_q;
  assign stk_data = stk_data_q;
  assign vec_rd   = vec_rd_q;
  assign vec_addr = vec_addr_q;
  assign new_pc   = new_pc_q;
  assign busy     = busy_q;
  assign ack_src  = ack_q;
  assign pc_load  = load_q;
  assign new_ccr  = nccr_q;
  assign new_xcr  = nxcr_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_accept;
    st_q == ITE_IDLE && take;
  endsequence

  sequence s_first_word;
    stk_wr_q && st_q == ITE_PUSH_PC && stk_data_q == {ccr_q, pc_q};
  endsequence

  sequence s_trap_accept;
    st_q == ITE_IDLE && trap_req && exec_state;
  endsequence

  a_push_first: assert property (@(posedge clk) disable iff (reset)
    s_accept |=> s_first_word)
    else $error("entry did not start with stack push");
  a_no_fetch_push: assert property (@(posedge clk) disable iff (reset)
    vec_rd_q |-> !stk_wr_q)
    else $error("vector fetch overlaps stack push");
  a_trace_clear: assert property (@(posedge clk) disable iff (reset)
    (st_q == ITE_MASK) |=> !nxcr_q[ITE_XCR_TRACE] && nccr_q[ITE_CCR_IMASK])
    else $error("trace bit not cleared or mask not set");
  a_level_upd: assert property (@(posedge clk) disable iff (reset)
    (st_q == ITE_MASK) |=> nxcr_q[2:0] == $past(lvl_q))
    else $error("mask level not updated");
  a_vec_addr: assert property (@(posedge clk) disable iff (reset)
    (st_q == ITE_MASK) |=> vec_rd_q && vec_addr_q == vec_to_addr($past(vec_q)))
    else $error("vector address wrong");
  a_pc_load: assert property (@(posedge clk) disable iff (reset)
    (st_q == ITE_VWAIT && vec_ack) |=> load_q && new_pc_q == $past(vec_data))
    else $error("handler address not loaded");
  a_trap_taken: assert property (@(posedge clk) disable iff (reset)
    s_trap_accept |=> ack_q ##0 busy_q)
    else $error("trap not accepted");
  a_trap_vec: assert property (@(posedge clk) disable iff (reset)
    s_trap_accept |=> vec_q == ITE_VEC_TRAP0 + {6'h00, $past(trap_num)})
    else $error("trap vector number wrong");
  a_nmi_taken: assert property (@(posedge clk) disable iff (reset)
    (st_q == ITE_IDLE && nmi_req && !(trap_req && exec_state))
      |=> ack_q && vec_q == ITE_VEC_NMI)
    else $error("nmi not accepted");
endmodule : ite_entry_seq

// ### inc/ite_pkg.sv
// package of constants and types for the exception entry sequencer
package ite_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ITE_PC_W     = 24;
  localparam int ITE_VEC_W    = 8;
  localparam int ITE_STK_W    = 32;
  // ---------------------------------------------------------------
  // extended control register fields
  // ---------------------------------------------------------------
  localparam int ITE_XCR_TRACE = 7;
  localparam int ITE_XCR_MSK_LO = 0;
  localparam int ITE_XCR_MSK_HI = 2;
  localparam logic [7:0] ITE_XCR_RESET = 8'h87;
  // condition flags: bit 7 is the interrupt mask
  localparam int ITE_CCR_IMASK = 7;
  localparam logic [7:0] ITE_CCR_RESET = 8'h80;
  // ---------------------------------------------------------------
  // vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] ITE_VEC_NMI      = 8'h07;
  localparam logic [7:0] ITE_VEC_TRAP0    = 8'h08;
  localparam logic [2:0] ITE_LVL_NMI      = 3'h7;
  localparam int         ITE_VEC_SHIFT    = 2;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ITE_IDLE   = 3'b000,
    ITE_PUSH_PC = 3'b001,
    ITE_PUSH_FL = 3'b010,
    ITE_MASK   = 3'b011,
    ITE_VREQ   = 3'b100,
    ITE_VWAIT  = 3'b101,
    ITE_DONE   = 3'b110
  } ite_state_t;
endpackage : ite_pkg

// ### rtl/ite_arbiter.sv
// source selection for exception entry: trap, nmi and masked interrupts
`timescale 1ns/1ps
module ite_arbiter
  import ite_pkg::*;
(
  // trap from decode
  input  wire logic                 trap_req,
  input  wire logic [1:0]           trap_num,
  // interrupt controller
  input  wire logic                 nmi_req,
  input  wire logic                 irq_req,
  input  wire logic [2:0]           irq_level,
  input  wire logic [ITE_VEC_W-1:0] irq_vector,
  input  wire logic                 mode_prio,
  // current masks
  input  wire logic                 ccr_imask,
  input  wire logic [2:0]           xcr_mask,
  // result
  output logic                      take,
  output logic [ITE_VEC_W-1:0]      vector,
  output logic [2:0]                new_level
);
  always_comb begin
    take      = 1'b0;
    vector    = '0;
    new_level = xcr_mask;
    if (trap_req) begin
      // trap ignores every mask
      take   = 1'b1;
      vector = ITE_VEC_TRAP0 + {6'h00, trap_num};
    end else if (nmi_req) begin
      take      = 1'b1;
      vector    = ITE_VEC_NMI;
      new_level = ITE_LVL_NMI;
    end else if (irq_req) begin
      // mode 0 gates on the flag mask, priority mode on the level
      if (mode_prio ? (irq_level > xcr_mask) : !ccr_imask) begin
        take      = 1'b1;
        vector    = irq_vector;
        new_level = irq_level;
      end
    end
  end
endmodule : ite_arbiter

// ### verification/ite_far_model.sv
// far-side model: stack memory and vector table with settable latency
`timescale 1ns/1ps
module ite_far_model
  import ite_pkg::*;
(
  // clock, reset and answer latency
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [3:0]           lat,
  // stack write port
  input  wire logic                 stk_wr,
  input  wire logic [ITE_STK_W-1:0] stk_data,
  output logic                      stk_ack,
  // vector fetch port
  input  wire logic                 vec_rd,
  input  wire logic [ITE_PC_W-1:0]  vec_addr,
  output logic                      vec_ack,
  output logic [ITE_PC_W-1:0]       vec_data,
  // what was seen, for the bench
  output logic [ITE_STK_W-1:0]      word1,
  output logic [ITE_STK_W-1:0]      word2,
  output logic [ITE_PC_W-1:0]       addr_seen
);
  logic [3:0] wait_q;
  logic       second_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {stk_ack, vec_ack, second_q, wait_q} <= '0;
      {vec_data, addr_seen, word1, word2} <= '0;
    end else begin
      stk_ack <= 1'b0;
      vec_ack <= 1'b0;
      // released data holds its last value one cycle, then is inverted every cycle
      if (!vec_ack) vec_data <= ~vec_data;
      if ((stk_wr && !stk_ack) || (vec_rd && !vec_ack)) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= lat) begin
          wait_q <= 4'h0;
          if (stk_wr) begin
            stk_ack  <= 1'b1;
            second_q <= !second_q;
            if (second_q) word2 <= stk_data;
            else word1 <= stk_data;
          end else begin
            vec_ack   <= 1'b1;
            addr_seen <= vec_addr;
            vec_data  <= {8'h40, vec_addr[15:0]};
          end
        end
      end
    end
  end
endmodule : ite_far_model

// ### verification/interrupt_trap_exception_entry_tb_top.sv
// self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
module interrupt_trap_exception_entry_tb_top;
  import ite_pkg::*;
  logic clk, reset, exec_state, trap_req, nmi_req, irq_req, mode_prio;
  logic stk_wr, stk_ack, vec_rd, vec_ack, busy, ack_src, pc_load;
  logic [1:0] trap_num;
  logic [2:0] irq_level;
  logic [3:0] lat;
  logic [7:0] cur_ccr, cur_xcr, irq_vector, new_ccr, new_xcr;
  logic [23:0] cur_pc, vec_addr, vec_data, new_pc, addr_seen;
  logic [31:0] stk_data, word1, word2;
  int bad_count, n_checks;

  ite_entry_seq DUT (.clk, .reset, .exec_state, .trap_req, .trap_num, .cur_pc, .cur_ccr,
    .cur_xcr, .nmi_req, .irq_req, .irq_level, .irq_vector, .mode_prio, .stk_wr, .stk_data,
    .stk_ack, .vec_rd, .vec_addr, .vec_ack, .vec_data, .busy, .ack_src, .pc_load, .new_pc,
    .new_ccr, .new_xcr);
  ite_far_model far (.clk, .reset, .lat, .stk_wr, .stk_data, .stk_ack, .vec_rd, .vec_addr,
    .vec_ack, .vec_data, .word1, .word2, .addr_seen);

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic drop();
    {trap_req, nmi_req, irq_req} = 3'b000;
  endtask : drop

  // one whole entry: accept, two pushes, masks, vector fetch, end
  task automatic entry(logic [7:0] vec, logic [2:0] lvl, logic chk_lvl);
    int i;
    logic [23:0] va;
    va = {14'h0, vec, 2'b00};
    i = 0;
    while (ack_src !== 1'b1 && i < 20) begin step(); i++; end
    check("ack_src", 1, ack_src);
    drop();
    i = 0;
    while (pc_load !== 1'b1 && i < 80) begin step(); i++; end
    check("pc_load", 1, pc_load);
    check("word1", {cur_ccr, cur_pc}, word1);
    check("word2", {24'h0, cur_xcr}, word2);
    check("vec_addr", va, addr_seen);
    check("new_pc", {8'h40, va[15:0]}, new_pc);
    check("new_ccr", cur_ccr | 8'h80, new_ccr);
    check("trace", 0, new_xcr[7]);
    if (chk_lvl) check("level", lvl, new_xcr[2:0]);
    step();
    check("busy", 0, busy);
  endtask : entry

  // request held ten cycles must not start an entry
  task automatic none();
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      step();
      seen = seen | busy | ack_src;
    end
    check("refused", 0, seen);
    drop();
  endtask : none

  task automatic t_traps();
    {mode_prio, cur_ccr, exec_state} = {1'b0, 8'h80, 1'b1};
    for (int n = 0; n < 4; n++) begin
      {trap_num, trap_req, cur_pc} = {n[1:0], 1'b1, 24'h123450 + 24'(n)};
      entry(ITE_VEC_TRAP0 + 8'(n), 3'h0, 1'b0);
    end
    {exec_state, trap_req} = 2'b01;
    none();
    exec_state = 1'b1;
  endtask : t_traps

  task automatic t_nmi();
    {cur_ccr, cur_xcr, lat} = {8'h80, 8'h87, 4'h3};
    for (int m = 0; m < 2; m++) begin
      // low mask level in priority mode, so the written level 7 shows
      {mode_prio, nmi_req, cur_xcr} = {m[0], 1'b1, m[0] ? 8'h82 : 8'h87};
      entry(ITE_VEC_NMI, ITE_LVL_NMI, m[0]);
    end
    lat = 4'h0;
  endtask : t_nmi

  task automatic t_irq();
    {mode_prio, cur_ccr, irq_vector, irq_req} = {1'b0, 8'h80, 8'h31, 1'b1};
    none();
    {cur_ccr, irq_req} = {8'h00, 1'b1};
    entry(8'h31, 3'h0, 1'b0);
    {mode_prio, cur_xcr} = {1'b1, 8'h84};
    for (int l = 0; l < 8; l++) begin
      {irq_level, irq_vector, irq_req} = {l[2:0], 8'h40 + 8'(l), 1'b1};
      if (l > 4) entry(8'h40 + 8'(l), l[2:0], 1'b1);
      else none();
    end
  endtask : t_irq

  task automatic t_prio();
    {trap_num, trap_req, nmi_req, irq_req, irq_level, lat} = {2'd2, 3'b111, 3'h7, 4'h2};
    entry(ITE_VEC_TRAP0 + 8'h2, 3'h0, 1'b0);
    {nmi_req, irq_req} = 2'b11;
    entry(ITE_VEC_NMI, ITE_LVL_NMI, 1'b1);
  endtask : t_prio

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #50000;
    bad_count++;
    give_verdict();
  end

  initial begin
    {reset, exec_state, trap_num, mode_prio, irq_level, lat} = {1'b1, 11'h000};
    drop();
    {cur_pc, cur_ccr, cur_xcr, irq_vector} = {24'h0, 8'h80, 8'h87, 8'h0};
    repeat (12) @(posedge clk);
    #1;
    check("reset ccr", ITE_CCR_RESET, new_ccr);
    check("reset xcr", ITE_XCR_RESET, new_xcr);
    reset = 1'b0;
    t_traps();
    t_nmi();
    t_irq();
    t_prio();
    give_verdict();
  end
endmodule : interrupt_trap_exception_entry_tb_top
